// >>> lcdcd_host.sv
`timescale 1ns/100ps
module lcdcd_host
	import lcdcd_pkg::*;
(
	// Clock and bus style
	input  wire logic       clk,
	input  wire logic       style,
	// Host pins
	output logic            cmd_data_select,
	output logic            wr_n,
	output logic            rd_n,
	output logic            enable,
	output logic            read_write,
	output logic [7:0]      d_in,
	input  wire logic [7:0] d_out,
	input  wire logic       d_oe_n
);
	initial
	begin
		cmd_data_select = 1'b0;
		wr_n            = 1'b1;
		rd_n            = 1'b1;
		enable          = 1'b0;
		read_write      = 1'b0;
		d_in            = 8'h00;
	end

	// One strobe cycle, active and idle five clocks each
	task automatic xfer(input logic a0, input logic rd, input logic [7:0] b,
		output logic [8:0] q);
	begin
		@(posedge clk);
		cmd_data_select <= a0;
		d_in            <= b;
		read_write      <= rd;
		enable          <= style;
		wr_n            <= style | rd;
		rd_n            <= style | ~rd;
		repeat (5) @(posedge clk);
		q = {d_oe_n, d_out};
		wr_n   <= 1'b1;
		rd_n   <= 1'b1;
		enable <= 1'b0;
		repeat (5) @(posedge clk);
		d_in <= ~b;
	end
	endtask
endmodule // lcdcd_host

// >>> lcdcd_if.sv
`timescale 1ns/100ps
interface lcdcd_if;
	logic       wr_evt;
	logic       wr_a0;
	logic [7:0] wr_data;
	logic       rd_act;
	logic       rd_a0;

	modport strobe (output wr_evt, wr_a0, wr_data, rd_act, rd_a0);
	modport core   (input wr_evt, wr_a0, wr_data, rd_act, rd_a0);
endinterface

// >>> lcdcd_pkg.sv
package lcdcd_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int RESET_DONE_NS  = 1000;
	localparam int RESET_DONE_CYC = RESET_DONE_NS / CLK_PERIOD_NS;
	localparam int INIT_CYC_DFLT  = 16;
	localparam int SYNC_STAGES    = 3;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	localparam int         REG_ADDR_W    = 4;
	localparam logic [3:0] REG_CTRL_OFS  = 4'h0;
	localparam logic [3:0] REG_STATE_OFS = 4'h4;
	localparam int         CTRL_STYLE_BIT = 0;
	localparam int         ST_ON_BIT     = 0;
	localparam int         ST_BUSY_BIT   = 1;
	localparam int         ST_START_LSB  = 8;
	localparam int         ST_PAGE_LSB   = 16;
	localparam int         ST_COL_LSB    = 24;

	// ----------------------------------------
	// Command patterns and status byte
	// ----------------------------------------
	localparam logic [6:0] CMD_ONOFF_PAT = 7'h57;
	localparam logic [1:0] CMD_START_PAT = 2'h1;
	localparam logic [3:0] CMD_PAGE_PAT  = 4'hB;
	localparam logic [3:0] CMD_COLHI_PAT = 4'h1;
	localparam logic [3:0] CMD_COLLO_PAT = 4'h0;
	localparam int         STAT_BUSY_BIT = 7;
	localparam int         STAT_OFF_BIT  = 5;
	localparam int         STAT_RST_BIT  = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic       DISP_ON_RST = 1'b0;
	localparam logic [5:0] START_RST   = 6'h00;
	localparam logic [3:0] PAGE_RST    = 4'h0;
	localparam logic [7:0] COL_RST     = 8'h00;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_ONOFF,
		CMD_START,
		CMD_PAGE,
		CMD_COLHI,
		CMD_COLLO
	} lcdcd_cmd_e;

	function automatic lcdcd_cmd_e lcdcd_decode(input logic [7:0] b);
		lcdcd_cmd_e k;
		k = CMD_NONE;
		if (b[7:1] == CMD_ONOFF_PAT)
			k = CMD_ONOFF;
		else if (b[7:6] == CMD_START_PAT)
			k = CMD_START;
		else if (b[7:4] == CMD_PAGE_PAT)
			k = CMD_PAGE;
		else if (b[7:4] == CMD_COLHI_PAT)
			k = CMD_COLHI;
		else if (b[7:4] == CMD_COLLO_PAT)
			k = CMD_COLLO;
		return k;
	endfunction

endpackage

// >>> lcdcd_strobe.sv
`timescale 1ns/100ps
module lcdcd_strobe
	import lcdcd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Bus style
	input  wire logic       style,
	// Host pins
	input  wire logic       cmd_data_select,
	input  wire logic       wr_n,
	input  wire logic       rd_n,
	input  wire logic       enable,
	input  wire logic       read_write,
	input  wire logic [7:0] d_in,
	// Events to core
	lcdcd_if.strobe         bus
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Pin order: a0, rw, en, rd active, wr active
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [7:0] d1;
		logic [7:0] d2;
		logic       act;
		logic [7:0] dlat;
		logic       alat;
		logic       evt;
		logic [7:0] edata;
		logic       ea0;
	} lcdcd_strb_s;

	lcdcd_strb_s q;
	lcdcd_strb_s d;
	logic        wact;

	always_comb
	begin
		d = q;
		d.s1 = {cmd_data_select, read_write, enable, ~rd_n, ~wr_n};
		d.s2 = q.s1;
		d.d1 = d_in;
		d.d2 = q.d1;
		wact = style ? (q.s2[2] & ~q.s2[3]) : q.s2[0];
		d.act = wact;
		if (wact)
		begin
			d.dlat = q.d2;
			d.alat = q.s2[4];
		end
		d.evt = q.act & ~wact;
		d.edata = q.dlat;
		d.ea0 = q.alat;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	assign bus.wr_evt  = q.evt;
	assign bus.wr_a0   = q.ea0;
	assign bus.wr_data = q.edata;
	assign bus.rd_act  = style ? (q.s2[2] & q.s2[3]) : q.s2[1];
	assign bus.rd_a0   = q.s2[4];

	chk_trailing_edge: assert property (@(posedge clk) disable iff (rst)
		q.act && !wact |=> q.evt && q.edata == $past(q.dlat))
		else $error("write event missed at strobe end");

endmodule // lcdcd_strobe

// >>> lcdcd_top.sv
`timescale 1ns/100ps
module lcdcd_top
	import lcdcd_pkg::*;
#(
	parameter int INIT_CYC = INIT_CYC_DFLT
)
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Host pins
	input  wire logic                  hw_reset_n,
	input  wire logic                  cmd_data_select,
	input  wire logic                  wr_n,
	input  wire logic                  rd_n,
	input  wire logic                  enable,
	input  wire logic                  read_write,
	input  wire logic [7:0]            d_in,
	output logic [7:0]                 d_out,
	output logic                       d_oe_n,
	// Display state
	output logic                       display_on,
	output logic [5:0]                 start_line,
	output logic [3:0]                 page_addr,
	output logic [7:0]                 col_addr,
	output logic                       busy,
	// Display RAM
	output logic                       ram_we,
	output logic [3:0]                 ram_page,
	output logic [7:0]                 ram_col,
	output logic [7:0]                 ram_wdata,
	input  wire logic [7:0]            ram_rdata,
	// Register port
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata
);

	localparam int CNT_W = $clog2(INIT_CYC + 1);

	if (INIT_CYC < 1 || INIT_CYC + SYNC_STAGES > RESET_DONE_CYC)
	begin : g_bad_init
		$error("INIT_CYC out of range");
	end

	// ----------------------------------------
	// Strobe decoding
	// ----------------------------------------
	lcdcd_if bus ();
	logic    style;

	lcdcd_strobe u_strobe (
		.clk             (clk),
		.rst             (rst),
		.style           (style),
		.cmd_data_select (cmd_data_select),
		.wr_n            (wr_n),
		.rd_n            (rd_n),
		.enable          (enable),
		.read_write      (read_write),
		.d_in            (d_in),
		.bus             (bus.strobe)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic             rs1;
		logic             rs2;
		logic [CNT_W-1:0] init_cnt;
		logic             disp_on;
		logic [5:0]       start;
		logic [3:0]       page;
		logic [7:0]       col;
		logic             style;
		logic             ram_we;
		logic [3:0]       ram_page;
		logic [7:0]       ram_col;
		logic [7:0]       ram_data;
		logic [7:0]       dout;
		logic             drive;
		logic [31:0]      rdata;
	} lcdcd_top_s;

	lcdcd_top_s q;
	lcdcd_top_s d;
	logic       busy_w;
	logic [7:0] status;

	always_comb
	begin
		d = q;
		d.rs1 = hw_reset_n;
		d.rs2 = q.rs1;
		d.ram_we = 1'b0;
		d.rdata = '0;
		busy_w = !q.rs2 || q.init_cnt != '0;
		status = 8'h00;
		status[STAT_BUSY_BIT] = busy_w;
		status[STAT_OFF_BIT] = ~q.disp_on;
		status[STAT_RST_BIT] = busy_w;
		if (!q.rs2)
		begin
			d.init_cnt = CNT_W'(INIT_CYC);
			d.disp_on = DISP_ON_RST;
			d.start = START_RST;
			d.page = PAGE_RST;
			d.col = COL_RST;
		end
		else if (q.init_cnt != '0)
			d.init_cnt = q.init_cnt - 1'b1;
		if (!busy_w && bus.wr_evt)
		begin
			if (bus.wr_a0)
			begin
				d.ram_we = 1'b1;
				d.ram_page = q.page;
				d.ram_col = q.col;
				d.ram_data = bus.wr_data;
				d.col = q.col + 8'h01;
			end
			else
			begin
				unique case (lcdcd_decode(bus.wr_data))
					CMD_ONOFF: d.disp_on = bus.wr_data[0];
					CMD_START: d.start = bus.wr_data[5:0];
					CMD_PAGE:  d.page = bus.wr_data[3:0];
					CMD_COLHI: d.col[7:4] = bus.wr_data[3:0];
					CMD_COLLO: d.col[3:0] = bus.wr_data[3:0];
					CMD_NONE:  d.col = q.col;
				endcase
			end
		end
		d.drive = bus.rd_act;
		if (bus.rd_act)
			d.dout = bus.rd_a0 ? ram_rdata : status;
		if (reg_wr && reg_addr == REG_CTRL_OFS)
			d.style = reg_wdata[CTRL_STYLE_BIT];
		if (reg_rd)
		begin
			if (reg_addr == REG_CTRL_OFS)
				d.rdata[CTRL_STYLE_BIT] = q.style;
			else if (reg_addr == REG_STATE_OFS)
			begin
				d.rdata[ST_ON_BIT] = q.disp_on;
				d.rdata[ST_BUSY_BIT] = busy_w;
				d.rdata[ST_START_LSB +: 6] = q.start;
				d.rdata[ST_PAGE_LSB +: 4] = q.page;
				d.rdata[ST_COL_LSB +: 8] = q.col;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign style      = q.style;
	assign d_out      = q.dout;
	assign d_oe_n     = ~q.drive;
	assign display_on = q.disp_on;
	assign start_line = q.start;
	assign page_addr  = q.page;
	assign col_addr   = q.col;
	assign busy       = busy_w;
	assign ram_we     = q.ram_we;
	assign ram_page   = q.ram_page;
	assign ram_col    = q.ram_col;
	assign ram_wdata  = q.ram_data;
	assign reg_rdata  = q.rdata;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int CHK_DONE = RESET_DONE_CYC;

	chk_reset_done: assert property (@(posedge clk) disable iff (rst)
		$rose(q.rs2) |-> ##[1:CHK_DONE] !busy_w)
		else $error("internal reset too long");

	chk_display_onoff: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && !bus.wr_a0 && bus.wr_data[7:1] == CMD_ONOFF_PAT
		|=> q.disp_on == $past(bus.wr_data[0]))
		else $error("display on/off not applied");

	chk_start_line: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && !bus.wr_a0 && bus.wr_data[7:6] == CMD_START_PAT
		|=> start_line == $past(bus.wr_data[5:0]))
		else $error("start line not loaded");

	chk_page_load: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && !bus.wr_a0 && bus.wr_data[7:4] == CMD_PAGE_PAT
		|=> page_addr == $past(bus.wr_data[3:0]))
		else $error("page address not loaded");

	chk_col_upper: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && !bus.wr_a0 && bus.wr_data[7:4] == CMD_COLHI_PAT
		|=> col_addr == {$past(bus.wr_data[3:0]), $past(q.col[3:0])})
		else $error("column upper nibble wrong");

	chk_col_lower: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && !bus.wr_a0 && bus.wr_data[7:4] == CMD_COLLO_PAT
		|=> col_addr == {$past(q.col[7:4]), $past(bus.wr_data[3:0])})
		else $error("column lower nibble wrong");

	chk_status_read: assert property (@(posedge clk) disable iff (rst)
		bus.rd_act && !bus.rd_a0 |=> !d_oe_n && d_out[3:0] == 4'h0
		&& d_out[STAT_OFF_BIT] == !$past(q.disp_on))
		else $error("status byte wrong");

	chk_ram_write: assert property (@(posedge clk) disable iff (rst)
		!busy_w && bus.wr_evt && bus.wr_a0 |=> ram_we && ram_wdata == $past(bus.wr_data)
		&& col_addr == $past(q.col) + 8'h01)
		else $error("display data not stored");

endmodule // lcdcd_top

// >>> tb.sv
`timescale 1ns/100ps
module tb;
	import lcdcd_pkg::*;
	logic        clk;
	logic        rst;
	logic        hw_reset_n;
	logic        style;
	logic        cmd_data_select;
	logic        wr_n;
	logic        rd_n;
	logic        enable;
	logic        read_write;
	logic [7:0]  d_in;
	logic [7:0]  d_out;
	logic        d_oe_n;
	logic        display_on;
	logic [5:0]  start_line;
	logic [3:0]  page_addr;
	logic [7:0]  col_addr;
	logic        busy;
	logic        ram_we;
	logic [3:0]  ram_page;
	logic [7:0]  ram_col;
	logic [7:0]  ram_wdata;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [8:0]  q;
	logic [31:0] r;
	int          miscompares;
	int          samples_checked;
	int          we_cnt;

	lcdcd_top #(.INIT_CYC(4)) u_dut (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
		.cmd_data_select(cmd_data_select), .wr_n(wr_n), .rd_n(rd_n), .enable(enable),
		.read_write(read_write), .d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n),
		.display_on(display_on), .start_line(start_line), .page_addr(page_addr),
		.col_addr(col_addr), .busy(busy), .ram_we(ram_we), .ram_page(ram_page),
		.ram_col(ram_col), .ram_wdata(ram_wdata), .ram_rdata(8'h5A),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	lcdcd_host u_host (.clk(clk), .style(style), .cmd_data_select(cmd_data_select),
		.wr_n(wr_n), .rd_n(rd_n), .enable(enable), .read_write(read_write),
		.d_in(d_in), .d_out(d_out), .d_oe_n(d_oe_n));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk)
		if (ram_we === 1'b1)
			we_cnt++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic complete_run;
	begin
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	end
	endtask

	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
	begin
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	end
	endtask

	task automatic wait_idle;
		int n;
	begin
		n = 0;
		while (busy !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(busy), 32'h0);
	end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
	begin
		wait_idle();
		bus_rd(REG_STATE_OFS, r);
		chk(r, 32'h0);
		bus_rd(4'h8, r);
		chk(r, 32'h0);
	end
	endtask

	task automatic t_cmds(input logic st, input logic [7:0] x);
	begin
		bus_wr(REG_CTRL_OFS, 32'(st));
		style <= st;
		u_host.xfer(1'b0, 1'b0, 8'hAF, q);
		chk(32'(display_on), 32'h1);
		u_host.xfer(1'b0, 1'b0, {2'h1, x[5:0]}, q);
		chk(32'(start_line), 32'(x[5:0]));
		u_host.xfer(1'b0, 1'b0, {4'hB, x[3:0]}, q);
		chk(32'(page_addr), 32'(x[3:0]));
		u_host.xfer(1'b0, 1'b0, {4'h1, x[7:4]}, q);
		chk(32'(col_addr[7:4]), 32'(x[7:4]));
		u_host.xfer(1'b0, 1'b0, {4'h0, x[3:0]}, q);
		chk(32'(col_addr), 32'(x));
		u_host.xfer(1'b0, 1'b1, 8'h00, q);
		chk(32'(q), 32'h000);
		bus_rd(REG_STATE_OFS, r);
		chk(r, {x, 4'h0, x[3:0], 2'h0, x[5:0], 8'h01});
		u_host.xfer(1'b0, 1'b0, 8'hAE, q);
		chk(32'(display_on), 32'h0);
		u_host.xfer(1'b0, 1'b1, 8'h00, q);
		chk(32'(q), 32'h020);
	end
	endtask

	task automatic t_data;
	begin
		we_cnt = 0;
		u_host.xfer(1'b1, 1'b0, 8'hAF, q);
		chk(32'(display_on), 32'h0);
		chk(32'(we_cnt), 32'h1);
		chk({ram_page, ram_col, ram_wdata}, 32'hE5EAF);
		u_host.xfer(1'b1, 1'b1, 8'h00, q);
		chk(32'(q), 32'h05A);
	end
	endtask

	task automatic t_hwrst;
	begin
		hw_reset_n <= 1'b0;
		repeat (200) @(posedge clk);
		chk({busy, start_line, page_addr, col_addr}, 32'h40000);
		hw_reset_n <= 1'b1;
		wait_idle();
		u_host.xfer(1'b0, 1'b0, 8'hAF, q);
		chk(32'(display_on), 32'h1);
	end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end

	initial
	begin
		rst             = 1'b1;
		hw_reset_n      = 1'b1;
		style           = 1'b0;
		reg_addr        = 4'h0;
		reg_wdata       = 32'h0;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		miscompares     = 0;
		samples_checked = 0;
		we_cnt          = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cmds(1'b0, 8'hC3);
		t_cmds(1'b1, 8'h5E);
		t_data();
		t_hwrst();
		complete_run();
	end
endmodule // tb
